// *** logic/fphc_config.v ***
// fphc_config.v: fault pin, input level, limit switch and homing configuration
// assumes: commands arrive decoded as cmd_valid pulses with cmd_code and cmd_arg
// Overview of operation
// - host picks one of five fault pin functions by command.
// - entering general output mode drives the output low at once.
// - fault flag assertion is delayed by a count of 10 ms units.
// - pulse mode uses a pulse count from 1 to 255.
// - general output goes low, high or inverts on the three commands.
// - a setting selects 24 V or 5 V digital input levels.
// - per-switch polarity bit picks rising/high or falling/low as effective.
// - per-switch block enable stops rotation in blocked direction while active.
// - per-switch bit: 1 blocks clockwise, 0 blocks anticlockwise.
// - during homing, enabled switch edges zero the position counter.
// - during homing, enabled switch edges stop the motor.
// - during homing, enabled switch edges send one serial character.
// - signed homing velocity stored, magnitude limited to 30000 rpm.
// - homing starts after power-on only when startup setting is 1.
// - one-shot zero bit zeroes position at edge, then clears; not saved.
// - one-shot stop bit stops motor at edge, then clears; not saved.
// - one-shot notice bit sends a character at edge, then clears; not saved.
// - configuration word query returns word, bit 0 is legacy behaviour.
// - bits 1 to 2 hold the low two bits of the reply policy.
// - bits 3 to 4 hold velocity source; bits 5 to 6 reserved zero.
// - bits 7 to 9 hold the operating mode.
// - bits 10 to 15 hold amplifier, position control, direction, limits, etc.
// - reply policy holds 0 to 7; 4 to 7 mute sequence-program replies.
`include "fphc_defines.vh"
module fphc_config #(
  parameter NSW          = 4,
  parameter TICK_CYCLES  = `FPHC_TICK_CYCLES
) (
  input  wire            ref_clk,
  input  wire            rst_n,
  input  wire            cmd_valid,
  input  wire [4:0]      cmd_code,
  input  wire [15:0]     cmd_arg,
  input  wire [NSW-1:0]  limit_in,
  input  wire            fault_cond,
  input  wire            pulse_src,
  input  wire            startup_homing_nv,
  input  wire            legacy_behaviour,
  input  wire [2:0]      reply_policy_in,
  input  wire            from_sequence,
  input  wire [1:0]      velocity_source,
  input  wire [2:0]      operating_mode,
  input  wire            amp_enabled,
  input  wire            pos_ctl_on,
  input  wire            analog_dir_right,
  input  wire            pos_limits_on,
  input  wire            smooth_commutation_only,
  input  wire            multidrop_link_mode,
  output reg             pin_out_q,
  output reg             pin_oe_q,
  output reg  [2:0]      pin_mode_q,
  output reg  [7:0]      pulse_count_q,
  output reg             high_voltage_q,
  output reg             block_cw_q,
  output reg             block_ccw_q,
  output reg             pos_zero_q,
  output reg             motor_stop_q,
  output reg             notify_char_q,
  output reg             homing_active_q,
  output reg  [15:0]     homing_velocity_q,
  output reg             reply_mute_q,
  output reg             cfg_valid_q,
  output reg  [15:0]     cfg_word_q
);
  reg  rs1_q;
  reg  rs2_q;
  wire rst_s_n = rs2_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end

  reg [NSW-1:0] pol_q;
  reg [NSW-1:0] blk_en_q;
  reg [NSW-1:0] blk_dir_q;
  reg [NSW-1:0] hm_zero_q;
  reg [NSW-1:0] hm_stop_q;
  reg [NSW-1:0] hm_note_q;
  reg [NSW-1:0] os_zero_q;
  reg [NSW-1:0] os_stop_q;
  reg [NSW-1:0] os_note_q;
  reg           startup_q;
  reg           boot_done_q;
  reg           boot_arm_q;
  reg [15:0]    delay_q;
  reg [15:0]    delay_cnt_q;
  reg [23:0]    tick_cnt_q;
  reg           gen_level_q;
  wire [NSW-1:0] act;
  wire [NSW-1:0] edg;

  genvar g;
  generate
    for (g = 0; g < NSW; g = g + 1) begin : g_sw
      fphc_edge_det u_det (
        .clk      (ref_clk),
        .rst_n    (rst_s_n),
        .sw_in    (limit_in[g]),
        .polarity (pol_q[g]),
        .active_q (act[g]),
        .edge_q   (edg[g])
      );
    end
  endgenerate

  wire       cmd  = cmd_valid;
  wire [NSW-1:0] arg_sw = cmd_arg[NSW-1:0];
  // clamp homing velocity to +/-30000 rpm
  wire [15:0] neg_lim = 16'h0000 - `FPHC_VEL_LIMIT;
  wire        arg_neg = cmd_arg[15];
  wire [15:0] vel_clamp = (!arg_neg && cmd_arg > `FPHC_VEL_LIMIT) ? `FPHC_VEL_LIMIT :
                          (arg_neg && cmd_arg < neg_lim) ? neg_lim : cmd_arg;
  wire [NSW-1:0] hm_ev   = homing_active_q ? edg : {NSW{1'b0}};
  wire           any_zero = |(hm_ev & hm_zero_q) | |(edg & os_zero_q);
  wire           any_stop = |(hm_ev & hm_stop_q) | |(edg & os_stop_q);
  wire           any_note = |(hm_ev & hm_note_q) | |(edg & os_note_q);

  // configuration and one-shot bits
  always @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pol_q <= {NSW{1'b0}};
      blk_en_q <= {NSW{1'b0}};
      blk_dir_q <= {NSW{1'b0}};
      hm_zero_q <= {NSW{1'b0}};
      hm_stop_q <= {NSW{1'b0}};
      hm_note_q <= {NSW{1'b0}};
      os_zero_q <= {NSW{1'b0}};
      os_stop_q <= {NSW{1'b0}};
      os_note_q <= {NSW{1'b0}};
      pin_mode_q <= `FPHC_MODE_FAULT;
      delay_q <= `FPHC_RST_FAULT_DELAY;
      pulse_count_q <= `FPHC_RST_PULSE_COUNT;
      high_voltage_q <= 1'b0;
      homing_velocity_q <= 16'h0000;
      startup_q <= 1'b0;
    end else begin
      if (cmd) begin
        case (cmd_code)
          `FPHC_CMD_FAULT_FLAG:  pin_mode_q <= `FPHC_MODE_FAULT;
          `FPHC_CMD_PULSE_EMIT:  pin_mode_q <= `FPHC_MODE_PULSE;
          `FPHC_CMD_GEN_OUTPUT:  pin_mode_q <= `FPHC_MODE_GENERAL;
          `FPHC_CMD_SENSE_IN:    pin_mode_q <= `FPHC_MODE_SENSE;
          `FPHC_CMD_LIMIT_IN:    pin_mode_q <= `FPHC_MODE_LIMIT;
          `FPHC_CMD_FAULT_DELAY: delay_q <= cmd_arg;
          `FPHC_CMD_PULSE_COUNT: begin
            // zero is out of range and ignored
            if (cmd_arg[15:8] == 8'h00 && cmd_arg[7:0] != 8'h00)
              pulse_count_q <= cmd_arg[7:0];
          end
          `FPHC_CMD_HIGH_VOLT:   high_voltage_q <= 1'b1;
          `FPHC_CMD_LOGIC_LVL:   high_voltage_q <= 1'b0;
          `FPHC_CMD_EDGE_POL:    pol_q <= arg_sw;
          `FPHC_CMD_BLOCK_EN:    blk_en_q <= arg_sw;
          `FPHC_CMD_BLOCK_DIR:   blk_dir_q <= arg_sw;
          `FPHC_CMD_HOME_ZERO:   hm_zero_q <= arg_sw;
          `FPHC_CMD_HOME_STOP:   hm_stop_q <= arg_sw;
          `FPHC_CMD_HOME_NOTIFY: hm_note_q <= arg_sw;
          `FPHC_CMD_HOME_VEL:    homing_velocity_q <= vel_clamp;
          `FPHC_CMD_STARTUP_HM:  startup_q <= cmd_arg[0];
          default: ;
        endcase
      end
      // the stored power-on homing setting is copied once; a host write replaces it
      if (!boot_done_q)
        startup_q <= startup_homing_nv;
      // one-shot bits: only the edge that acted on a bit clears it, so a write
      // landing with an edge arms the next edge rather than being lost unused
      os_zero_q <= (cmd && cmd_code == `FPHC_CMD_ONE_ZERO) ? arg_sw
                   : (os_zero_q & ~edg);
      os_stop_q <= (cmd && cmd_code == `FPHC_CMD_ONE_STOP) ? arg_sw
                   : (os_stop_q & ~edg);
      os_note_q <= (cmd && cmd_code == `FPHC_CMD_ONE_NOTICE) ? arg_sw
                   : (os_note_q & ~edg);
    end
  end

  // homing run control; the power-on run starts one cycle after the setting copy,
  // so the boot decision always reads a settled setting
  always @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      boot_done_q <= 1'b0;
      boot_arm_q <= 1'b0;
      homing_active_q <= 1'b0;
    end else begin
      boot_done_q <= 1'b1;
      boot_arm_q <= !boot_done_q;
      if (boot_arm_q && startup_q)
        homing_active_q <= 1'b1;
      else if (cmd && cmd_code == `FPHC_CMD_RUN_HOMING)
        homing_active_q <= 1'b1;
      else if (|(hm_ev & hm_stop_q) || (cmd && cmd_code == `FPHC_CMD_HOMING_END))
        homing_active_q <= 1'b0;
    end
  end

  // edge actions and blocking
  always @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pos_zero_q <= 1'b0;
      motor_stop_q <= 1'b0;
      notify_char_q <= 1'b0;
      block_cw_q <= 1'b0;
      block_ccw_q <= 1'b0;
    end else begin
      pos_zero_q <= any_zero;
      motor_stop_q <= any_stop;
      notify_char_q <= any_note;
      block_cw_q <= |(act & blk_en_q & blk_dir_q);
      block_ccw_q <= |(act & blk_en_q & ~blk_dir_q);
    end
  end

  // fault delay: 10 ms tick divider and delay counter
  // the divider idles while no fault is present, so every delay starts on a full unit
  wire tick = (tick_cnt_q == TICK_CYCLES - 1);
  wire fault_ok = (delay_cnt_q >= delay_q);
  always @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      tick_cnt_q <= 24'h000000;
      delay_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= (!fault_cond || tick) ? 24'h000000 : tick_cnt_q + 24'h000001;
      if (!fault_cond)
        delay_cnt_q <= 16'h0000;
      else if (tick && !fault_ok)
        delay_cnt_q <= delay_cnt_q + 16'h0001;
    end
  end

  // pin driver
  always @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      gen_level_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      if (cmd && cmd_code == `FPHC_CMD_GEN_OUTPUT)
        gen_level_q <= 1'b0;
      else if (cmd && cmd_code == `FPHC_CMD_DRIVE_LOW)
        gen_level_q <= 1'b0;
      else if (cmd && cmd_code == `FPHC_CMD_DRIVE_HIGH)
        gen_level_q <= 1'b1;
      else if (cmd && cmd_code == `FPHC_CMD_INVERT)
        gen_level_q <= ~gen_level_q;
      case (pin_mode_q)
        `FPHC_MODE_FAULT: begin
          pin_out_q <= fault_cond & fault_ok;
          pin_oe_q <= 1'b1;
        end
        `FPHC_MODE_PULSE: begin
          pin_out_q <= pulse_src;
          pin_oe_q <= 1'b1;
        end
        `FPHC_MODE_GENERAL: begin
          pin_out_q <= gen_level_q;
          pin_oe_q <= 1'b1;
        end
        default: begin
          pin_out_q <= 1'b0;
          pin_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // configuration word fields; bits 5 and 6 are reserved and read as zero
  reg [15:0] cfg_word_d;
  always @* begin
    cfg_word_d = 16'h0000;
    cfg_word_d[`FPHC_CW_LEGACY] = legacy_behaviour;
    cfg_word_d[`FPHC_CW_REPLY_LO +: 2] = reply_policy_in[1:0];
    cfg_word_d[`FPHC_CW_SOURCE_LO +: 2] = velocity_source;
    cfg_word_d[`FPHC_CW_MODE_LO +: 3] = operating_mode;
    cfg_word_d[`FPHC_CW_AMP] = amp_enabled;
    cfg_word_d[`FPHC_CW_POSCTL] = pos_ctl_on;
    cfg_word_d[`FPHC_CW_ADIR] = analog_dir_right;
    cfg_word_d[`FPHC_CW_LIMITS] = pos_limits_on;
    cfg_word_d[`FPHC_CW_SMOOTH] = smooth_commutation_only;
    cfg_word_d[`FPHC_CW_MULTIDROP] = multidrop_link_mode;
  end

  // configuration word answer
  always @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      cfg_valid_q <= 1'b0;
      cfg_word_q <= 16'h0000;
      reply_mute_q <= 1'b0;
    end else begin
      reply_mute_q <= reply_policy_in[2] & from_sequence;
      cfg_valid_q <= cmd && cmd_code == `FPHC_CMD_CFG_QUERY;
      if (cmd && cmd_code == `FPHC_CMD_CFG_QUERY)
        cfg_word_q <= cfg_word_d;
    end
  end
endmodule // fphc_config

// *** logic/fphc_defines.vh ***
// fphc_defines.vh: constants of the fault pin, limit switch and homing configuration block
// assumes: included by bare name from the design files under logic/
`ifndef FPHC_DEFINES_VH
`define FPHC_DEFINES_VH
// fault pin functions, command codes on cmd_code
`define FPHC_CMD_NONE        5'h00
`define FPHC_CMD_FAULT_FLAG  5'h01
`define FPHC_CMD_PULSE_EMIT  5'h02
`define FPHC_CMD_GEN_OUTPUT  5'h03
`define FPHC_CMD_SENSE_IN    5'h04
`define FPHC_CMD_LIMIT_IN    5'h05
`define FPHC_CMD_FAULT_DELAY 5'h06
`define FPHC_CMD_PULSE_COUNT 5'h07
`define FPHC_CMD_DRIVE_LOW   5'h08
`define FPHC_CMD_DRIVE_HIGH  5'h09
`define FPHC_CMD_INVERT      5'h0a
`define FPHC_CMD_HIGH_VOLT   5'h0b
`define FPHC_CMD_LOGIC_LVL   5'h0c
`define FPHC_CMD_EDGE_POL    5'h0d
`define FPHC_CMD_BLOCK_EN    5'h0e
`define FPHC_CMD_BLOCK_DIR   5'h0f
`define FPHC_CMD_HOME_ZERO   5'h10
`define FPHC_CMD_HOME_STOP   5'h11
`define FPHC_CMD_HOME_NOTIFY 5'h12
`define FPHC_CMD_HOME_VEL    5'h13
`define FPHC_CMD_STARTUP_HM  5'h14
`define FPHC_CMD_RUN_HOMING  5'h15
`define FPHC_CMD_ONE_ZERO    5'h16
`define FPHC_CMD_ONE_STOP    5'h17
`define FPHC_CMD_ONE_NOTICE  5'h18
`define FPHC_CMD_CFG_QUERY   5'h19
`define FPHC_CMD_HOMING_END  5'h1a
// fault pin mode register encoding
`define FPHC_MODE_FAULT      3'h0
`define FPHC_MODE_PULSE      3'h1
`define FPHC_MODE_GENERAL    3'h2
`define FPHC_MODE_SENSE      3'h3
`define FPHC_MODE_LIMIT      3'h4
// configuration word field positions
`define FPHC_CW_LEGACY       0
`define FPHC_CW_REPLY_LO     1
`define FPHC_CW_SOURCE_LO    3
`define FPHC_CW_MODE_LO      7
`define FPHC_CW_AMP          10
`define FPHC_CW_POSCTL       11
`define FPHC_CW_ADIR         12
`define FPHC_CW_LIMITS       13
`define FPHC_CW_SMOOTH       14
`define FPHC_CW_MULTIDROP    15
// reset values and limits
`define FPHC_RST_FAULT_DELAY 16'h0000
`define FPHC_RST_PULSE_COUNT 8'h01
`define FPHC_VEL_LIMIT       16'h7530
// fault delay unit is 1/100 s = 10 ms, clock period 100 ns
`define FPHC_DELAY_UNIT_NS   10000000
`define FPHC_CLK_PERIOD_NS   100
`define FPHC_TICK_CYCLES     (`FPHC_DELAY_UNIT_NS / `FPHC_CLK_PERIOD_NS)
`endif

// *** logic/fphc_edge_det.v ***
// fphc_edge_det.v: synchroniser and effective-edge detector for one limit switch
// assumes: single clock, rst_n already synchronised by the top
module fphc_edge_det (
  input  wire clk,
  input  wire rst_n,
  input  wire sw_in,
  input  wire polarity,
  output reg  active_q,
  output reg  edge_q
);
  reg sync1_q;
  reg sync2_q;
  reg prev_q;
  wire lvl = polarity ? sync2_q : ~sync2_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      prev_q   <= 1'b0;
      active_q <= 1'b0;
      edge_q   <= 1'b0;
    end else begin
      sync1_q  <= sw_in;
      sync2_q  <= sync1_q;
      prev_q   <= sync2_q;
      active_q <= lvl;
      // rising edge when polarity is 1, falling when 0
      edge_q   <= polarity ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);
    end
  end
endmodule // fphc_edge_det

// *** tb/fphc_config_monitor.sv ***
// fphc_config_monitor.sv: port assertions for the configuration block
// assumes: bound into fphc_config, command codes from fphc_defines.vh
`include "fphc_defines.vh"
module fphc_monitor #(
  parameter NSW = 4
) (
  input wire           ref_clk,
  input wire           rst_n,
  input wire           cmd_valid,
  input wire [4:0]     cmd_code,
  input wire [15:0]    cmd_arg,
  input wire [NSW-1:0] limit_in,
  input wire           legacy_behaviour,
  input wire [2:0]     reply_policy_in,
  input wire           from_sequence,
  input wire [1:0]     velocity_source,
  input wire [2:0]     operating_mode,
  input wire           amp_enabled,
  input wire           pos_ctl_on,
  input wire           analog_dir_right,
  input wire           pos_limits_on,
  input wire           smooth_commutation_only,
  input wire           multidrop_link_mode,
  input wire           pin_out_q,
  input wire           pin_oe_q,
  input wire [2:0]     pin_mode_q,
  input wire [7:0]     pulse_count_q,
  input wire [15:0]    homing_velocity_q,
  input wire           pos_zero_q,
  input wire           motor_stop_q,
  input wire           notify_char_q,
  input wire           reply_mute_q,
  input wire           cfg_valid_q,
  input wire [15:0]    cfg_word_q
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [31:0]        take = cmd_valid ? (32'h1 << cmd_code) : 32'h0;
  wire [6:0]         lo_exp = {2'b00, velocity_source, reply_policy_in[1:0], legacy_behaviour};
  wire [8:0]         hi_exp = {multidrop_link_mode, smooth_commutation_only, pos_limits_on,
                               analog_dir_right, pos_ctl_on, amp_enabled, operating_mode};
  wire               mute_src = reply_policy_in[2] & from_sequence;
  wire               gen_md = pin_mode_q == `FPHC_MODE_GENERAL;
  wire               bad_cnt = cmd_arg == 16'h0000 || cmd_arg > 16'h00ff;
  wire [7:0]         arg_lo = cmd_arg[7:0];
  wire signed [15:0] arg_s = cmd_arg;
  // clamp is on the signed value; an unsigned compare would clip every reverse speed
  wire [15:0]        vel_exp = (arg_s > 16'sh7530) ? 16'h7530 :
                               (arg_s < 16'sh8ad0) ? 16'h8ad0 : cmd_arg;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence sw_edge_s;
    $past(limit_in, 4) != $past(limit_in, 5);
  endsequence
  sequence inv_cmd_s;
    take[`FPHC_CMD_INVERT] && gen_md ##1 1'b1;
  endsequence
  cfg_low_a: assert property (
    take[`FPHC_CMD_CFG_QUERY] |=> cfg_valid_q && cfg_word_q[6:0] == $past(lo_exp))
    else $error("config word low fields wrong");
  cfg_high_a: assert property (
    take[`FPHC_CMD_CFG_QUERY] |=> cfg_word_q[15:7] == $past(hi_exp))
    else $error("config word high fields wrong");
  gen_low_a: assert property (
    take[`FPHC_CMD_GEN_OUTPUT] |-> ##2 pin_oe_q && !pin_out_q)
    else $error("general output not low on entry");
  drive_high_a: assert property (
    take[`FPHC_CMD_DRIVE_HIGH] && gen_md |-> ##2 pin_out_q)
    else $error("general output not driven high");
  out_toggle_a: assert property (
    inv_cmd_s |=> pin_out_q != $past(pin_out_q))
    else $error("general output did not invert");
  count_load_a: assert property (
    take[`FPHC_CMD_PULSE_COUNT] && !bad_cnt |=> pulse_count_q == $past(arg_lo))
    else $error("pulse count not loaded");
  count_refuse_a: assert property (
    take[`FPHC_CMD_PULSE_COUNT] && bad_cnt |=> $stable(pulse_count_q))
    else $error("illegal pulse count accepted");
  vel_clamp_a: assert property (
    take[`FPHC_CMD_HOME_VEL] |=> homing_velocity_q == $past(vel_exp))
    else $error("homing velocity not clamped");
  input_mode_a: assert property (
    pin_mode_q >= `FPHC_MODE_SENSE |=> !pin_oe_q)
    else $error("pin driven in an input mode");
  mute_follow_a: assert property (
    reply_mute_q == $past(mute_src))
    else $error("reply mute does not follow policy");
  edge_pulse_a: assert property (
    pos_zero_q || motor_stop_q || notify_char_q |-> sw_edge_s)
    else $error("switch action without a synchronised edge");
endmodule // fphc_monitor

bind fphc_config fphc_monitor #(.NSW(NSW)) u_monitor (.*);

// *** tb/fphc_host_model.sv ***
// fphc_host_model.sv: host side of the decoded command port
// assumes: serial framing already stripped, one command per call
`include "fphc_defines.vh"
module fphc_host_model (
  input  wire        ref_clk,
  input  wire        cfg_valid_q,
  input  wire [15:0] cfg_word_q,
  output reg         cmd_valid,
  output reg  [4:0]  cmd_code,
  output reg  [15:0] cmd_arg
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = `FPHC_CMD_NONE;
    cmd_arg = 16'h0000;
  end
  // argument is scrambled after the taking edge so a stale value never looks valid
  task issue(input [4:0] c, input [15:0] a);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg <= a;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_code <= `FPHC_CMD_NONE;
    cmd_arg <= ~a;
  endtask
  task send(input [4:0] c, input [15:0] a);
    issue(c, a);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task query(output [15:0] w, output v);
    issue(`FPHC_CMD_CFG_QUERY, 16'h0000);
    #1;
    v = cfg_valid_q;
    w = cfg_word_q;
  endtask
endmodule // fphc_host_model

// *** tb/test_fault_pin_homing_config.sv ***
// test_fault_pin_homing_config.sv: directed command sequences on the configuration block
// assumes: fphc_host_model issues commands, fphc_monitor bound to the design
`include "fphc_defines.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module test_fault_pin_homing_config;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [24:0]  GC = {`FPHC_CMD_DRIVE_LOW, `FPHC_CMD_INVERT, `FPHC_CMD_INVERT,
                          `FPHC_CMD_DRIVE_HIGH, `FPHC_CMD_GEN_OUTPUT};
  localparam [95:0]  PC = {16'h0001, 8'h01, 16'h0100, 8'hff, 16'h0000, 8'hff, 16'h00ff, 8'hff};
  localparam [127:0] VL = {16'h7531, 16'h7530, 16'hfc18, 16'hfc18,
                           16'h8000, 16'h8ad0, 16'h7fff, 16'h7530};
  reg        ref_clk = 1'b0, rst_n = 1'b0, fault_cond = 1'b0, pulse_src = 1'b0;
  reg        startup_homing_nv = 1'b0, v;
  reg [3:0]  limit_in = 4'h0;
  reg [15:0] st = 16'h0000, w, p;
  int        mismatches = 0, samples_checked = 0, nz = 0, ns = 0, nn = 0, bz, bs, bn, i;
  wire       cmd_valid, pin_out_q, pin_oe_q, high_voltage_q, block_cw_q, block_ccw_q;
  wire       pos_zero_q, motor_stop_q, notify_char_q, homing_active_q, reply_mute_q;
  wire       cfg_valid_q;
  wire [4:0] cmd_code;
  wire [2:0] pin_mode_q;
  wire [7:0] pulse_count_q;
  wire [15:0] cmd_arg, homing_velocity_q, cfg_word_q;
  wire       legacy_behaviour = st[0], from_sequence = st[1], amp_enabled = st[2];
  wire [2:0] reply_policy_in = st[5:3], operating_mode = st[8:6];
  wire [1:0] velocity_source = st[10:9];
  wire       pos_ctl_on = st[11], analog_dir_right = st[12], pos_limits_on = st[13];
  wire       smooth_commutation_only = st[14], multidrop_link_mode = st[15];
  fphc_config #(.NSW(4), .TICK_CYCLES(4)) dut (.*);
  fphc_host_model host (.*);
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    pulse_src <= ~pulse_src;
    nz <= nz + pos_zero_q;
    ns <= ns + motor_stop_q;
    nn <= nn + notify_char_q;
  end
  task finish_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task do_reset(input bit nv);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    startup_homing_nv <= nv;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task sw(input int k, input bit lv);
    @(posedge ref_clk);
    limit_in[k] <= lv;
    repeat (7) @(posedge ref_clk);
    #1;
  endtask
  task pulses(input int z, input int s, input int n);
    `CHK("zero pulses", z, nz - bz)
    `CHK("stop pulses", s, ns - bs)
    `CHK("notify pulses", n, nn - bn)
    bz = nz;
    bs = ns;
    bn = nn;
  endtask
  initial begin
    #(4000 * 100);
    mismatches++;
    finish_test;
  end
  initial begin
    do_reset(1'b0);
    `CHK("pulse count", 8'h01, pulse_count_q)
    `CHK("homing", 1'b0, homing_active_q)
    for (i = 0; i < 5; i++) begin
      host.send(5'(`FPHC_CMD_FAULT_FLAG + i), 16'h0000);
      `CHK("pin mode", i[2:0], pin_mode_q)
      `CHK("pin enable", i < 3, pin_oe_q)
      if (i == 1) `CHK("pulse pin", ~pulse_src, pin_out_q)
    end
    for (i = 0; i < 5; i++) begin
      host.send(GC[i*5 +: 5], 16'h0000);
      `CHK("pin level", i[0], pin_out_q)
    end
    for (i = 0; i < 4; i++) begin
      host.send(`FPHC_CMD_PULSE_COUNT, PC[i*24+8 +: 16]);
      `CHK("pulse count", PC[i*24 +: 8], pulse_count_q)
    end
    host.send(`FPHC_CMD_HIGH_VOLT, 16'h0000);
    `CHK("input level", 1'b1, high_voltage_q)
    host.send(`FPHC_CMD_LOGIC_LVL, 16'h0000);
    `CHK("input level", 1'b0, high_voltage_q)
    host.send(`FPHC_CMD_FAULT_FLAG, 16'h0000);
    host.send(`FPHC_CMD_FAULT_DELAY, 16'h0002);
    @(posedge ref_clk);
    fault_cond <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK("fault early", 1'b0, pin_out_q)
    repeat (10) @(posedge ref_clk);
    #1;
    `CHK("fault late", 1'b1, pin_out_q)
    @(posedge ref_clk);
    fault_cond <= 1'b0;
    for (i = 0; i < 4; i++) begin
      host.send(`FPHC_CMD_HOME_VEL, VL[i*32+16 +: 16]);
      `CHK("homing velocity", VL[i*32 +: 16], homing_velocity_q)
    end
    host.send(`FPHC_CMD_EDGE_POL, 16'h0001);
    host.send(`FPHC_CMD_BLOCK_EN, 16'h0001);
    host.send(`FPHC_CMD_BLOCK_DIR, 16'h0001);
    `CHK("block cw", 1'b0, block_cw_q)
    sw(0, 1'b1);
    `CHK("block cw", 1'b1, block_cw_q)
    host.send(`FPHC_CMD_BLOCK_DIR, 16'h0000);
    `CHK("block ccw", 1'b1, block_ccw_q)
    `CHK("block cw", 1'b0, block_cw_q)
    sw(0, 1'b0);
    `CHK("block ccw", 1'b0, block_ccw_q)
    pulses(0, 0, 0);
    for (i = 0; i < 3; i++) begin
      host.send(5'(`FPHC_CMD_ONE_ZERO + i), 16'h0001);
    end
    sw(0, 1'b1);
    pulses(1, 1, 1);
    sw(0, 1'b0);
    sw(0, 1'b1);
    pulses(0, 0, 0);
    for (i = 0; i < 3; i++) begin
      host.send(5'(`FPHC_CMD_HOME_ZERO + i), 16'h0004);
    end
    sw(2, 1'b1);
    sw(2, 1'b0);
    pulses(0, 0, 0);
    host.send(`FPHC_CMD_RUN_HOMING, 16'h0000);
    `CHK("homing", 1'b1, homing_active_q)
    sw(2, 1'b1);
    pulses(0, 0, 0);
    sw(2, 1'b0);
    pulses(1, 1, 1);
    `CHK("homing", 1'b0, homing_active_q)
    for (i = 0; i < 2; i++) begin
      p = i ? 16'h5a1c : 16'ha5e3;
      @(posedge ref_clk);
      st <= p;
      host.query(w, v);
      `CHK("word valid", 1'b1, v)
      `CHK("word", {p[15:11], p[2], p[8:6], 2'b00, p[10:9], p[4:3], p[0]}, w)
      `CHK("reply mute", p[5] & p[1], reply_mute_q)
    end
    @(posedge ref_clk);
    st <= 16'h0000;
    do_reset(1'b1);
    `CHK("startup homing", 1'b1, homing_active_q)
    finish_test;
  end
endmodule // test_fault_pin_homing_config
